// ### design/lsc_pkg.sv
package lsc_pkg;

    // ----------------------------------------
    // register map
    // ----------------------------------------
    localparam int LSC_NUM_LDO = 2;
    localparam logic [7:0] LSC_CORE_ADDR = 8'h43;
    localparam logic [7:0] LSC_PANEL_ADDR = 8'h46;
    localparam logic [7:0] LSC_CORE_RESET = 8'h3c;
    localparam logic [7:0] LSC_PANEL_RESET = 8'h24;
    localparam logic [7:0] LSC_UNMAPPED_READ = 8'h00;

    // ----------------------------------------
    // field layout
    // ----------------------------------------
    localparam int LSC_STATE_LSB = 0;
    localparam int LSC_STATE_MSB = 2;
    localparam int LSC_TARGET_LSB = 3;
    localparam int LSC_TARGET_MSB = 5;
    localparam int LSC_FIELD_W = 3;
    localparam logic [1:0] LSC_RESERVED_READ = 2'h0;

    // ----------------------------------------
    // state codes
    // ----------------------------------------
    typedef enum logic [2:0] {
        LSC_CODE_OFF = 3'h4,
        LSC_CODE_LOWPWR = 3'h5,
        LSC_CODE_ACTIVE = 3'h6,
        LSC_CODE_ACTIVE_ALT = 3'h7
    } lsc_code_type;

    typedef struct packed {
        logic enable;
        logic lowPower;
        logic discharge;
    } lsc_drive_type;

    // codes 4..7 carry bit 2; 0..3 are reserved or no-copy
    function automatic logic lsc_is_valid_code(input logic [2:0] code);
        return code[2];
    endfunction

    function automatic lsc_drive_type lsc_decode(input logic [2:0] code);
        lsc_drive_type d;
        d.enable = code[2] && (code != LSC_CODE_OFF);
        d.lowPower = (code == LSC_CODE_LOWPWR);
        // reserved codes park the rail off and discharged, the safe side
        d.discharge = !d.enable;
        return d;
    endfunction

    function automatic logic [7:0] lsc_slot_addr(input int idx);
        return (idx == 0) ? LSC_CORE_ADDR : LSC_PANEL_ADDR;
    endfunction

    function automatic logic [7:0] lsc_slot_reset(input int idx);
        return (idx == 0) ? LSC_CORE_RESET : LSC_PANEL_RESET;
    endfunction

endpackage

// ### design/lsc_ldo_slot.sv
`timescale 1ns/100ps
module lsc_ldo_slot #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic wrEn,
    input wire logic [7:0] wrData,
    input wire logic exitPulse,
    input wire logic ocFaultPin,
    input wire logic uvFaultPin,
    output logic [7:0] ctrlReg,
    output lsc_pkg::lsc_drive_type drive,
    output logic faultEvent
);

    // ----------------------------------------
    // control fields
    // ----------------------------------------
    logic [2:0] stateSel;
    logic [2:0] exitTarget;
    logic [2:0] next_stateSel;
    logic [2:0] next_exitTarget;
    logic copyHit;

    // stored target is used, so a write in the same cycle cannot race the copy
    assign copyHit = exitPulse && lsc_pkg::lsc_is_valid_code(exitTarget); // [RULE2] [RULE3]
    assign next_exitTarget = wrEn ?
        wrData[lsc_pkg::LSC_TARGET_MSB:lsc_pkg::LSC_TARGET_LSB] : exitTarget;
    assign next_stateSel = copyHit ? exitTarget : // [RULE2]
        (wrEn ? wrData[lsc_pkg::LSC_STATE_MSB:lsc_pkg::LSC_STATE_LSB] : stateSel); // [RULE1]
    assign ctrlReg = {lsc_pkg::LSC_RESERVED_READ, exitTarget, stateSel}; // [RULE10]

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            stateSel <= RESET_VALUE[lsc_pkg::LSC_STATE_MSB:lsc_pkg::LSC_STATE_LSB];
            exitTarget <= RESET_VALUE[lsc_pkg::LSC_TARGET_MSB:lsc_pkg::LSC_TARGET_LSB];
            drive <= lsc_pkg::lsc_decode(
                RESET_VALUE[lsc_pkg::LSC_STATE_MSB:lsc_pkg::LSC_STATE_LSB]);
        end
        else
        begin
            stateSel <= next_stateSel;
            exitTarget <= next_exitTarget;
            drive <= lsc_pkg::lsc_decode(next_stateSel); // [RULE1] [RULE9]
        end
    end

    // ----------------------------------------
    // output monitors
    // ----------------------------------------
    logic [1:0] ocSync;
    logic [1:0] uvSync;
    logic faultSeen;
    logic faultNow;

    assign faultNow = ocSync[1] || uvSync[1];

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ocSync <= 2'h0;
            uvSync <= 2'h0;
            faultSeen <= 1'b0;
            faultEvent <= 1'b0;
        end
        else
        begin
            ocSync <= {ocSync[0], ocFaultPin};
            uvSync <= {uvSync[0], uvFaultPin};
            faultSeen <= faultNow;
            faultEvent <= faultNow && !faultSeen; // [RULE8]
        end
    end

endmodule

// ### design/lsc_regs.sv
`timescale 1ns/100ps
// Notes on behaviour
// [RULE1] state code: 4 off, 5 low, 6/7 active
// [RULE2] exit pin copies target 4..7 into state
// [RULE3] target 0..3 leaves state untouched on exit
// [RULE4] controller programs exit targets after power-up
// [RULE5] core register 0x43, resets to 0x3c
// [RULE6] panel register 0x46, resets to 0x24
// [RULE7] each regulator has its own independent register
// [RULE8] over-current or under-voltage raises an event
// [RULE9] off state actively discharges the output
// [RULE10] bits 7:6 ignore writes, read zero
module lsc_regs (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    output logic regRdValid,
    input wire logic standbyExitPin,
    input wire logic [1:0] ocFaultPin,
    input wire logic [1:0] uvFaultPin,
    output lsc_pkg::lsc_drive_type [1:0] ldoDrive,
    output logic [1:0] faultEvent
);

    // ----------------------------------------
    // standby exit detect
    // ----------------------------------------
    logic [1:0] exitSync;
    logic exitLast;
    logic exitPulse;

    // only the rising edge copies; a held pin must not fight later writes
    assign exitPulse = exitSync[1] && !exitLast; // [RULE2]

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            exitSync <= 2'h0;
            exitLast <= 1'b0;
        end
        else
        begin
            exitSync <= {exitSync[0], standbyExitPin};
            exitLast <= exitSync[1];
        end
    end

    // ----------------------------------------
    // regulator slots
    // ----------------------------------------
    logic [7:0] ctrlReg [lsc_pkg::LSC_NUM_LDO];
    logic [lsc_pkg::LSC_NUM_LDO-1:0] addrHit;

    for (genvar i = 0; i < lsc_pkg::LSC_NUM_LDO; i++)
    begin : g_slot
        assign addrHit[i] = (regAddr == lsc_pkg::lsc_slot_addr(i)); // [RULE5] [RULE6] [RULE7]

        lsc_ldo_slot #(
            .RESET_VALUE(lsc_pkg::lsc_slot_reset(i)) // [RULE5] [RULE6]
        ) u_slot (
            .mclk(mclk),
            .rst_n(rst_n),
            .wrEn(regWrEn && addrHit[i]), // [RULE7]
            .wrData(regWrData),
            .exitPulse(exitPulse),
            .ocFaultPin(ocFaultPin[i]),
            .uvFaultPin(uvFaultPin[i]),
            .ctrlReg(ctrlReg[i]),
            .drive(ldoDrive[i]),
            .faultEvent(faultEvent[i])
        );
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [7:0] readValue;

    always_comb
    begin
        readValue = lsc_pkg::LSC_UNMAPPED_READ;
        for (int i = 0; i < lsc_pkg::LSC_NUM_LDO; i++)
        begin
            if (addrHit[i])
            begin
                readValue = ctrlReg[i];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            regRdData <= lsc_pkg::LSC_UNMAPPED_READ;
            regRdValid <= 1'b0;
        end
        else
        begin
            regRdValid <= regRdEn;
            if (regRdEn)
            begin
                regRdData <= readValue;
            end
        end
    end

endmodule

// ### bench/lsc_regs_chk.sv
`timescale 1ns/100ps
module lsc_regs_chk (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    input wire logic [1:0] ocFaultPin,
    input wire logic [1:0] uvFaultPin,
    input wire lsc_pkg::lsc_drive_type [1:0] ldoDrive,
    input wire logic [1:0] faultEvent
);
    // ----
    // checks
    // ----
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    chk_rd_valid: assert property (regRdEn |=> regRdValid)
        else $error("read valid late");
    // reset value 0x3c carries state code 4, so the core rail starts off
    chk_core_reset: assert property ($rose(rst_n) |-> ldoDrive[0] == 3'h1)
        else $error("core reset drive");
    chk_panel_reset: assert property ($rose(rst_n) |-> ldoDrive[1] == 3'h1)
        else $error("panel reset drive");
    chk_resv_zero: assert property (regRdValid |-> regRdData[7:6] == 2'h0)
        else $error("reserved bits set");
    chk_off_drain: assert property (regWrEn && regAddr == 8'h46 && regWrData[2:0] == 3'h4
        |=> ldoDrive[1].discharge && !ldoDrive[1].enable) else $error("discharge wrong");
    chk_lowpwr_wr: assert property (regWrEn && regAddr == 8'h46 && regWrData[2:0] == 3'h5
        |=> ldoDrive[1] == 3'h6) else $error("low power drive");
    chk_core_alone: assert property (regWrEn && regAddr == 8'h46 |=> $stable(ldoDrive[0]))
        else $error("core moved");
    chk_fault_evt: assert property ($rose(ocFaultPin[1] | uvFaultPin[1])
        |-> ##[1:4] faultEvent[1]) else $error("no fault event");
    cov_read: cover property (regRdValid);
    cov_fault: cover property (faultEvent[1]);
    cov_core_wr: cover property (regWrEn && regAddr == 8'h43);
endmodule
bind lsc_regs lsc_regs_chk u_chk (.mclk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .regRdValid, .ocFaultPin, .uvFaultPin, .ldoDrive, .faultEvent);

// ### bench/lsc_host.sv
`timescale 1ns/100ps
module lsc_host (
    input wire logic mclk,
    input wire logic [7:0] regRdData,
    input wire logic regRdValid,
    output logic [7:0] regAddr = 8'h00,
    output logic regWrEn = 1'b0,
    output logic [7:0] regWrData = 8'h00,
    output logic regRdEn = 1'b0,
    output logic standbyExitPin = 1'b0
);
    // ----
    // bus tasks
    // ----
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge mclk);
        regWrEn <= 1'b0;
        regWrData <= ~d; // released data must not look valid
    endtask
    // latency is fixed at one cycle, so no polling
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output bit ok);
        @(posedge mclk);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge mclk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1;
        ok = (regRdValid === 1'b1);
        d = regRdData;
    endtask
    task automatic exitPulse;
        @(posedge mclk);
        standbyExitPin <= 1'b1;
        repeat (6) @(posedge mclk);
        standbyExitPin <= 1'b0;
    endtask
endmodule

// ### bench/test_ldo_state_control_regs.sv
`timescale 1ns/100ps
module test_ldo_state_control_regs;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] flt = 4'h0;
    logic [7:0] regAddr, regWrData, regRdData, rd;
    logic regWrEn, regRdEn, regRdValid, standbyExitPin;
    lsc_pkg::lsc_drive_type [1:0] ldoDrive;
    logic [1:0] faultEvent;
    int errors = 0;
    int samples_checked = 0;
    bit ok;
    always #5 mclk = ~mclk;
    lsc_host P (.mclk, .regRdData, .regRdValid, .regAddr, .regWrEn, .regWrData, .regRdEn,
        .standbyExitPin);
    lsc_regs DUT (.mclk, .rst_n, .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData,
        .regRdValid, .standbyExitPin, .ocFaultPin(flt[1:0]), .uvFaultPin(flt[3:2]), .ldoDrive,
        .faultEvent);
    // ----
    // scenarios
    // ----
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        P.rd(a, rd, ok);
        if (!ok)
        begin
            errors++;
            test_done();
        end
        check(rd, exp);
    endtask
    task automatic t_codes;
        for (int c = 0; c < 8; c++)
        begin
            P.wr(8'h46, 8'hc0 | c[7:0]);
            rdchk(8'h46, c[7:0]);
            check({5'h0, ldoDrive[1]}, c == 5 ? 8'h6 : c > 5 ? 8'h4 : 8'h1);
        end
        rdchk(8'h43, 8'h3c);
    endtask
    task automatic t_exit;
        P.wr(8'h43, 8'h26);
        P.wr(8'h46, 8'h15);
        P.exitPulse();
        rdchk(8'h43, 8'h24);
        rdchk(8'h46, 8'h15);
        check({5'h0, ldoDrive[0]}, 8'h1);
    endtask
    // second reset after both registers moved away from their reset values
    task automatic t_reset;
        @(posedge mclk);
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        #1;
        check({5'h0, ldoDrive[0]}, 8'h1);
        check({5'h0, ldoDrive[1]}, 8'h1);
        rdchk(8'h43, 8'h3c);
        rdchk(8'h46, 8'h24);
    endtask
    task automatic t_fault;
        int n;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge mclk);
            flt[i] <= 1'b1;
            n = 0;
            repeat (8)
            begin
                @(posedge mclk);
                #1;
                if (faultEvent[i % 2] === 1'b1)
                    n++;
            end
            check(n[7:0], 8'h1);
            @(posedge mclk);
            flt <= 4'h0;
            repeat (4) @(posedge mclk);
        end
    endtask
    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        rdchk(8'h43, 8'h3c);
        rdchk(8'h46, 8'h24);
        rdchk(8'h44, 8'h00);
        t_codes();
        t_exit();
        t_fault();
        t_reset();
        test_done();
    end
endmodule
